/* hw/ecb_map.svh */
// Notes on behaviour
// - An up counter adds one on each rising edge of its count input and ignores a steady level.
// - While an up counter's reset input is on, its value is held at zero and its status is off.
// - Up and stage counters count past the preset and stop at 9999 until reset.
// - An up/down counter's status, and an up counter's while its reset is off, is on when its value is at or above its preset, else off.
// - A counter's value is read at data-word address counter number plus octal 1000.
// - The bank holds counters 0 to octal 77, picked by a counter reference.
// - The preset of up and stage counters is a constant 0 to 9999 or a memory word.
// - A stage counter has one input and adds one on each rising edge of it.
// - A stage counter holds its value whatever its reset input does until a reset instruction.
// - A stage counter's status stays on once reached; a reset instruction clears value and status.
// - An up/down counter adds one on an up rising edge while down is off and subtracts one on a down rising edge while up is off.
// - While an up/down counter's reset input is on, its value is forced to zero.
// - An up/down counter holds 8 digits with a top count of 99999999.
// - An up/down counter takes two consecutive counter numbers.
// - An up/down counter's value is a double word at counter number plus octal 1000 and the next.
`ifndef ECB_MAP_SVH
`define ECB_MAP_SVH
`define ECB_NUM_CTR    64
`define ECB_LAST_REF   6'h3F
`define ECB_MAX_SHORT  16'h270F
`define ECB_MAX_LONG   32'h05F5_E0FF
`define ECB_VAL_BASE   16'h0200
`define ECB_VAL_TOP    16'h0240
`endif

/* hw/ecb_pkg.sv */
package ecb_pkg;
    typedef enum logic [1:0] {
        ECB_UP_COUNTER_OP,
        ECB_STAGE_COUNTER_OP,
        ECB_UP_DOWN_COUNTER_OP,
        ECB_RESET_INSTR_OP
    } ecb_op_t;

    typedef struct packed {
        logic        valid;
        ecb_op_t     op;
        logic [5:0]  counter_ref;
        logic        in_up;
        logic        in_down;
        logic        in_reset;
        logic [31:0] preset;
    } ecb_cmd_t;

    typedef struct packed {
        logic        en;
        logic [15:0] addr;
    } ecb_rd_req_t;
endpackage

/* hw/ecb_event_counter_bank.sv */
`timescale 1ns/1ps
`include "ecb_map.svh"

module ecb_event_counter_bank
    import ecb_pkg::*;
#(
    parameter int NUM_CTR = `ECB_NUM_CTR
) (
    input  wire logic          clk_sys,
    input  wire logic          reset_n,
    input  wire logic          clk_en,
    input  wire ecb_cmd_t      cmd,
    input  wire ecb_rd_req_t   rd_req,
    output logic [15:0]        rd_data_q,
    output logic               rd_valid_q,
    output logic [NUM_CTR-1:0] status_q
);

    // Value words, one per counter number; an up/down counter uses two
    logic [15:0]        mem_q [NUM_CTR];
    logic [15:0]        mem_d [NUM_CTR];
    logic [NUM_CTR-1:0] status_d;
    logic [NUM_CTR-1:0] prev_up_q;
    logic [NUM_CTR-1:0] prev_up_d;
    logic [NUM_CTR-1:0] prev_dn_q;
    logic [NUM_CTR-1:0] prev_dn_d;
    logic [15:0]        rd_data_d;
    logic               rd_valid_d;

    logic [5:0]         sel;
    logic [5:0]         sel_hi;
    logic [15:0]        val_short;
    logic [31:0]        val_long;
    logic               rise_up;
    logic               rise_dn;
    logic [15:0]        nxt_short;
    logic [31:0]        nxt_long;
    logic               rd_hit;

    always_comb begin
        sel       = cmd.counter_ref;
        sel_hi    = 6'(sel + 6'd1);
        val_short = mem_q[sel];
        val_long  = {mem_q[sel_hi], mem_q[sel]};
        rise_up   = cmd.in_up & ~prev_up_q[sel];
        rise_dn   = cmd.in_down & ~prev_dn_q[sel];
    end

    always_comb begin
        mem_d     = mem_q;
        status_d  = status_q;
        prev_up_d = prev_up_q;
        prev_dn_d = prev_dn_q;
        nxt_short = val_short;
        nxt_long  = val_long;
        if (cmd.valid) begin
            case (cmd.op)
                ECB_UP_COUNTER_OP: begin
                    prev_up_d[sel] = cmd.in_up;
                    if (cmd.in_reset) begin
                        mem_d[sel]    = 16'h0000;
                        status_d[sel] = 1'b0;
                    end else begin
                        if (rise_up && val_short < `ECB_MAX_SHORT) begin
                            nxt_short = 16'(val_short + 16'd1);
                        end
                        mem_d[sel]    = nxt_short;
                        status_d[sel] = {16'h0000, nxt_short} >= cmd.preset;
                    end
                end
                ECB_STAGE_COUNTER_OP: begin
                    // Reset input is ignored; only the reset instruction clears
                    prev_up_d[sel] = cmd.in_up;
                    if (rise_up && val_short < `ECB_MAX_SHORT) begin
                        nxt_short = 16'(val_short + 16'd1);
                    end
                    mem_d[sel]    = nxt_short;
                    status_d[sel] = status_q[sel]
                                  | ({16'h0000, nxt_short} >= cmd.preset);
                end
                ECB_UP_DOWN_COUNTER_OP: begin
                    // Top number has no partner word, so it is refused
                    if (sel != `ECB_LAST_REF) begin
                        prev_up_d[sel] = cmd.in_up;
                        prev_dn_d[sel] = cmd.in_down;
                        if (cmd.in_reset) begin
                            nxt_long = 32'h0000_0000;
                        end else if (rise_up && !cmd.in_down) begin
                            if (val_long < `ECB_MAX_LONG) begin
                                nxt_long = 32'(val_long + 32'd1);
                            end
                        end else if (rise_dn && !cmd.in_up) begin
                            if (val_long != 32'h0000_0000) begin
                                nxt_long = 32'(val_long - 32'd1);
                            end
                        end
                        mem_d[sel]    = nxt_long[15:0];
                        mem_d[sel_hi] = nxt_long[31:16];
                        status_d[sel] = nxt_long >= cmd.preset;
                    end
                end
                ECB_RESET_INSTR_OP: begin
                    mem_d[sel]    = 16'h0000;
                    status_d[sel] = 1'b0;
                end
                default: begin
                    mem_d = mem_q;
                end
            endcase
        end
    end

    always_comb begin
        rd_hit     = rd_req.en && rd_req.addr >= `ECB_VAL_BASE
                   && rd_req.addr < `ECB_VAL_TOP;
        rd_data_d  = rd_hit ? mem_q[rd_req.addr[5:0]] : 16'h0000;
        rd_valid_d = rd_req.en;
    end

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            mem_q      <= '{default: 16'h0000};
            status_q   <= '0;
            prev_up_q  <= '0;
            prev_dn_q  <= '0;
            rd_data_q  <= 16'h0000;
            rd_valid_q <= 1'b0;
        end else if (clk_en) begin
            mem_q      <= mem_d;
            status_q   <= status_d;
            prev_up_q  <= prev_up_d;
            prev_dn_q  <= prev_dn_d;
            rd_data_q  <= rd_data_d;
            rd_valid_q <= rd_valid_d;
        end
    end

    // Checking helpers: the counter touched last and its value afterwards
    logic [5:0]  aref_q;
    logic [15:0] post_short;
    logic [31:0] post_long;
    logic        go;

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            aref_q <= 6'h00;
        end else if (clk_en) begin
            aref_q <= sel;
        end
    end

    always_comb begin
        go         = clk_en && cmd.valid;
        post_short = mem_q[aref_q];
        post_long  = {mem_q[6'(aref_q + 6'd1)], mem_q[aref_q]};
    end

    a_up_edge_count: assert property (@(posedge clk_sys) disable iff (!reset_n)
        go && cmd.op == ECB_UP_COUNTER_OP && !cmd.in_reset && rise_up
        && val_short < `ECB_MAX_SHORT |=> post_short == 16'($past(val_short) + 16'd1))
        else $error("up counter missed an edge");

    a_up_level_hold: assert property (@(posedge clk_sys) disable iff (!reset_n)
        go && cmd.op == ECB_UP_COUNTER_OP && !cmd.in_reset && !rise_up
        |=> post_short == $past(val_short))
        else $error("up counter moved without an edge");

    a_up_reset_clear: assert property (@(posedge clk_sys) disable iff (!reset_n)
        go && cmd.op == ECB_UP_COUNTER_OP && cmd.in_reset
        |=> post_short == 16'h0000 && !status_q[aref_q])
        else $error("up counter reset did not clear");

    a_short_sat_hold: assert property (@(posedge clk_sys) disable iff (!reset_n)
        go && (cmd.op == ECB_UP_COUNTER_OP || cmd.op == ECB_STAGE_COUNTER_OP)
        && !(cmd.op == ECB_UP_COUNTER_OP && cmd.in_reset) && val_short == `ECB_MAX_SHORT
        |=> post_short == `ECB_MAX_SHORT)
        else $error("short counter left its top count");

    a_up_status_cmp: assert property (@(posedge clk_sys) disable iff (!reset_n)
        go && cmd.op == ECB_UP_COUNTER_OP && !cmd.in_reset
        |=> status_q[aref_q] == ({16'h0000, post_short} >= $past(cmd.preset)))
        else $error("up counter status disagrees with preset");

    a_val_read_back: assert property (@(posedge clk_sys) disable iff (!reset_n)
        clk_en && rd_req.en && rd_req.addr == `ECB_VAL_BASE
        |=> rd_valid_q && rd_data_q == $past(mem_q[0]))
        else $error("value word not read at base address");

    a_stage_sticky: assert property (@(posedge clk_sys) disable iff (!reset_n)
        go && cmd.op == ECB_STAGE_COUNTER_OP && status_q[sel] |=> status_q[aref_q])
        else $error("stage status dropped without reset instruction");

    a_clr_instr: assert property (@(posedge clk_sys) disable iff (!reset_n)
        go && cmd.op == ECB_RESET_INSTR_OP
        |=> post_short == 16'h0000 && !status_q[aref_q])
        else $error("reset instruction did not clear counter");

    a_ud_up_count: assert property (@(posedge clk_sys) disable iff (!reset_n)
        go && cmd.op == ECB_UP_DOWN_COUNTER_OP && sel != `ECB_LAST_REF && !cmd.in_reset
        && rise_up && !cmd.in_down && val_long < `ECB_MAX_LONG
        |=> post_long == 32'($past(val_long) + 32'd1))
        else $error("up/down counter missed an up edge");

    a_ud_reset_zero: assert property (@(posedge clk_sys) disable iff (!reset_n)
        go && cmd.op == ECB_UP_DOWN_COUNTER_OP && sel != `ECB_LAST_REF && cmd.in_reset
        |=> post_long == 32'h0000_0000)
        else $error("up/down reset did not zero value");

    a_ud_floor: assert property (@(posedge clk_sys) disable iff (!reset_n)
        go && cmd.op == ECB_UP_DOWN_COUNTER_OP && sel != `ECB_LAST_REF
        && val_long == 32'h0000_0000 && !cmd.in_reset && !rise_up
        |=> post_long == 32'h0000_0000)
        else $error("up/down counter went below zero");

    a_stage_edge_count: assert property (@(posedge clk_sys) disable iff (!reset_n)
        go && cmd.op == ECB_STAGE_COUNTER_OP && rise_up && val_short < `ECB_MAX_SHORT
        |=> post_short == 16'($past(val_short) + 16'h0001))
        else $error("stage counter missed an edge");

    a_stage_level_hold: assert property (@(posedge clk_sys) disable iff (!reset_n)
        go && cmd.op == ECB_STAGE_COUNTER_OP && !rise_up
        |=> post_short == $past(val_short))
        else $error("stage counter moved without an edge");

    a_stage_rst_ignored: assert property (@(posedge clk_sys) disable iff (!reset_n)
        go && cmd.op == ECB_STAGE_COUNTER_OP && cmd.in_reset && !rise_up
        |=> post_short == $past(val_short) && (!$past(status_q[sel]) || status_q[aref_q]))
        else $error("stage counter obeyed its reset input");

    a_stage_status_cmp: assert property (@(posedge clk_sys) disable iff (!reset_n)
        go && cmd.op == ECB_STAGE_COUNTER_OP && !status_q[sel]
        |=> status_q[aref_q] == ({16'h0000, post_short} >= $past(cmd.preset)))
        else $error("stage status disagrees with preset");

    a_ud_status_cmp: assert property (@(posedge clk_sys) disable iff (!reset_n)
        go && cmd.op == ECB_UP_DOWN_COUNTER_OP && sel != `ECB_LAST_REF
        |=> status_q[aref_q] == (post_long >= $past(cmd.preset)))
        else $error("up/down status disagrees with preset");

    a_ud_down_count: assert property (@(posedge clk_sys) disable iff (!reset_n)
        go && cmd.op == ECB_UP_DOWN_COUNTER_OP && sel != `ECB_LAST_REF && !cmd.in_reset
        && rise_dn && !cmd.in_up && val_long != 32'h0000_0000
        |=> post_long == 32'($past(val_long) - 32'h0000_0001))
        else $error("up/down counter missed a down edge");

    a_ud_level_hold: assert property (@(posedge clk_sys) disable iff (!reset_n)
        go && cmd.op == ECB_UP_DOWN_COUNTER_OP && sel != `ECB_LAST_REF && !cmd.in_reset
        && !rise_up && !rise_dn
        |=> post_long == $past(val_long))
        else $error("up/down counter moved without an edge");

    a_ud_last_refused: assert property (@(posedge clk_sys) disable iff (!reset_n)
        go && cmd.op == ECB_UP_DOWN_COUNTER_OP && sel == `ECB_LAST_REF
        |=> post_short == $past(val_short) && status_q[aref_q] == $past(status_q[sel])
        && mem_q[6'h00] == $past(mem_q[6'h00]))
        else $error("up/down command on the top number was not ignored");

    a_ud_partner_status: assert property (@(posedge clk_sys) disable iff (!reset_n)
        go && cmd.op == ECB_UP_DOWN_COUNTER_OP && sel != `ECB_LAST_REF
        |=> status_q[6'(aref_q + 6'h01)] == $past(status_q[sel_hi]))
        else $error("up/down counter touched its partner status");

    a_ud_reset_status: assert property (@(posedge clk_sys) disable iff (!reset_n)
        go && cmd.op == ECB_UP_DOWN_COUNTER_OP && sel != `ECB_LAST_REF && cmd.in_reset
        |=> status_q[aref_q] == ($past(cmd.preset) == 32'h0000_0000))
        else $error("up/down status wrong after reset");

    a_up_sat_edge: assert property (@(posedge clk_sys) disable iff (!reset_n)
        go && cmd.op == ECB_UP_COUNTER_OP && !cmd.in_reset && rise_up
        && val_short >= `ECB_MAX_SHORT |=> post_short == $past(val_short))
        else $error("up counter counted past its top count");

    a_rd_window_zero: assert property (@(posedge clk_sys) disable iff (!reset_n)
        clk_en && rd_req.en && (rd_req.addr < `ECB_VAL_BASE || rd_req.addr >= `ECB_VAL_TOP)
        |=> rd_data_q == 16'h0000)
        else $error("read outside the value window returned data");

    a_counter_read: assert property (@(posedge clk_sys) disable iff (!reset_n)
        clk_en && rd_req.en && rd_req.addr >= `ECB_VAL_BASE && rd_req.addr < `ECB_VAL_TOP
        |=> rd_data_q == $past(mem_q[6'(rd_req.addr - `ECB_VAL_BASE)]))
        else $error("value word read from the wrong counter");

    a_rd_valid_set: assert property (@(posedge clk_sys) disable iff (!reset_n)
        clk_en && rd_req.en
        |=> rd_valid_q)
        else $error("read was not answered");

    a_rd_valid_pulse: assert property (@(posedge clk_sys) disable iff (!reset_n)
        clk_en && !rd_req.en
        |=> !rd_valid_q)
        else $error("read answer without a read");

    a_idle_status_keep: assert property (@(posedge clk_sys) disable iff (!reset_n)
        clk_en && !cmd.valid
        |=> status_q == $past(status_q))
        else $error("status moved without a command");

    a_status_one_ref: assert property (@(posedge clk_sys) disable iff (!reset_n)
        go
        |=> ((status_q ^ $past(status_q)) & ~(NUM_CTR'(1'b1) << aref_q)) == '0)
        else $error("command changed the status of another counter");

    a_freeze_hold: assert property (@(posedge clk_sys) disable iff (!reset_n)
        !clk_en
        |=> status_q == $past(status_q) && rd_data_q == $past(rd_data_q)
        && rd_valid_q == $past(rd_valid_q) && post_short == $past(post_short))
        else $error("state moved while clock enable was low");

    a_clr_edge_keep: assert property (@(posedge clk_sys) disable iff (!reset_n)
        go && cmd.op == ECB_RESET_INSTR_OP
        |=> prev_up_q == $past(prev_up_q) && prev_dn_q == $past(prev_dn_q))
        else $error("reset instruction changed edge memory");

    a_clr_partner_keep: assert property (@(posedge clk_sys) disable iff (!reset_n)
        go && cmd.op == ECB_RESET_INSTR_OP && sel != `ECB_LAST_REF
        |=> mem_q[6'(aref_q + 6'h01)] == $past(mem_q[sel_hi]))
        else $error("reset instruction cleared the next word");

endmodule // ecb_event_counter_bank

/* testbench/ecb_ctl_model.sv */
`timescale 1ns/1ps
module ecb_ctl_model
    import ecb_pkg::*;
(
    output ecb_cmd_t    cmd,
    output ecb_rd_req_t rd_req
);
    initial begin
        cmd    = '0;
        rd_req = '0;
    end
    task automatic put(input ecb_op_t o, input logic [5:0] r, input logic up, input logic dn,
                       input logic rs, input logic [31:0] p);
        cmd = '{1'b1, o, r, up & ~dn, dn, rs, p};
    endtask
    task automatic rd(input logic [15:0] a);
        rd_req = '{1'b1, a};
    endtask
    // Released lines show the inverse of their last value
    task automatic idle_cmd();
        ecb_cmd_t c;
        c       = ~cmd;
        c.valid = 1'b0;
        cmd     = c;
    endtask
    task automatic idle_rd();
        ecb_rd_req_t q;
        q      = ~rd_req;
        q.en   = 1'b0;
        rd_req = q;
    endtask
endmodule // ecb_ctl_model

/* testbench/tb_top.sv */
`timescale 1ns/1ps
`include "ecb_map.svh"
module tb_top
    import ecb_pkg::*;
;
    logic        clk_sys = 1'b0;
    logic        reset_n = 1'b0;
    logic        clk_en  = 1'b1;
    ecb_cmd_t    cmd;
    ecb_rd_req_t rd_req;
    logic [15:0] rd_data_q;
    logic        rd_valid_q;
    logic [63:0] status_q;
    longint      w [64];
    bit          s [64];
    bit          lu [64];
    bit          ld [64];
    int          bad_count  = 0;
    int          n_compared = 0;
    logic [31:0] lf         = 32'h0000_71E7;

    always #12.5 clk_sys = ~clk_sys;

    function automatic logic [31:0] lfsr_next(input logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction

    ecb_ctl_model i_ctl (.cmd(cmd), .rd_req(rd_req));
    ecb_event_counter_bank i_dut (.clk_sys(clk_sys), .reset_n(reset_n), .clk_en(clk_en),
        .cmd(cmd), .rd_req(rd_req), .rd_data_q(rd_data_q), .rd_valid_q(rd_valid_q),
        .status_q(status_q));

    task automatic summarize();
        $display("compared %0d mismatches %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    task automatic cmp(input string n, input longint e, input logic [31:0] g);
        n_compared++;
        if (g !== e) begin
            bad_count++;
            $display("BAD %s expected %0h seen %0h", n, e, g);
        end
    endtask

    task automatic mdl();
        int r;
        longint v;
        longint p;
        logic up;
        logic dn;
        r  = cmd.counter_ref;
        p  = cmd.preset;
        up = cmd.in_up;
        dn = cmd.in_down;
        case (cmd.op)
            ECB_UP_COUNTER_OP: begin
                if (cmd.in_reset) begin
                    w[r] = 0;
                    s[r] = 0;
                end else begin
                    if (up && !lu[r] && w[r] < `ECB_MAX_SHORT) w[r]++;
                    s[r] = w[r] >= p;
                end
                lu[r] = up;
            end
            ECB_STAGE_COUNTER_OP: begin
                if (up && !lu[r] && w[r] < `ECB_MAX_SHORT) w[r]++;
                s[r]  = s[r] || w[r] >= p;
                lu[r] = up;
            end
            ECB_UP_DOWN_COUNTER_OP: if (r < 63) begin
                v = w[r+1] * 65536 + w[r];
                if (cmd.in_reset) v = 0;
                else if (up && !lu[r] && !dn && v < `ECB_MAX_LONG) v++;
                else if (dn && !ld[r] && !up && v > 0) v--;
                w[r]   = v % 65536;
                w[r+1] = v / 65536;
                s[r]   = v >= p;
                lu[r]  = up;
                ld[r]  = dn;
            end
            default: begin
                w[r] = 0;
                s[r] = 0;
            end
        endcase
    endtask

    task automatic rdchk(input logic [15:0] a, input longint e);
        @(posedge clk_sys);
        #2;
        clk_en = 1'b1;
        i_ctl.idle_cmd();
        i_ctl.rd(a);
        @(posedge clk_sys);
        #2;
        i_ctl.idle_rd();
        cmp("rd_valid", 1, rd_valid_q);
        cmp("rd_data", e, rd_data_q);
    endtask

    task automatic op(input ecb_op_t o, input int r, input logic up, input logic dn,
                      input logic rs, input logic [31:0] p, input logic ce);
        @(posedge clk_sys);
        #2;
        clk_en = ce;
        i_ctl.put(o, r[5:0], up, dn, rs, p);
        if (ce) mdl();
        rdchk(`ECB_VAL_BASE + 16'(r), w[r]);
        cmp("status", s[r], status_q[r]);
        if (o == ECB_UP_DOWN_COUNTER_OP && r < 63)
            rdchk(`ECB_VAL_BASE + 16'(r + 1), w[r+1]);
    endtask

    initial begin
        #(25 * 90000);
        bad_count++;
        summarize();
    end

    initial begin
        repeat (2) @(posedge clk_sys);
        #2 reset_n = 1'b1;
        rdchk(`ECB_VAL_BASE - 16'h0001, 0);
        rdchk(`ECB_VAL_TOP, 0);
        for (int i = 0; i < 20004; i++)
            op(ECB_UP_COUNTER_OP, 9, i[0], 1'b0, 1'b0, 32'h0000_270F, 1'b1);
        rdchk(16'h01C9, 0);
        rdchk(16'h0249, 0);
        for (int i = 0; i < 4000; i++) begin
            lf = lfsr_next(lf);
            op(ecb_op_t'(lf[1:0]), (lf[4:2] == 3'h7) ? 63 : int'(lf[3:2]), lf[5], lf[6],
               lf[12:10] == 3'h0, {29'h0000_0000, lf[18:16]}, lf[15:13] != 3'h0);
        end
        summarize();
    end
endmodule // tb_top
